// [hdl/mhs_pkg.sv]
// constants, register map and types shared by the modem host and serial port block
// assumes a 100 MHz core clock; long counts are overridable at the top module
package mhs_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BIT_RATE_BPS = 2400;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;

  localparam int unsigned RING_MIN_PERIOD_US = 14700;
  localparam int unsigned RING_MAX_PERIOD_US = 65400;
  localparam int unsigned RING_MIN_CYCLES = RING_MIN_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RING_MAX_CYCLES = RING_MAX_PERIOD_US * (CLK_HZ / 1_000_000);

  localparam int unsigned DIAL_BREAK_MS = 60;
  localparam int unsigned DIAL_MAKE_MS = 40;
  localparam int unsigned DIAL_BREAK_CYCLES = DIAL_BREAK_MS * (CLK_HZ / 1000);
  localparam int unsigned DIAL_MAKE_CYCLES = DIAL_MAKE_MS * (CLK_HZ / 1000);

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BIT_CNT_W = 16;
  localparam int unsigned LONG_CNT_W = 24;

  localparam logic [4:0] ADDR_RX_DATA = 5'h00;
  localparam logic [4:0] ADDR_CTRL = 5'h09;
  localparam logic [4:0] ADDR_STATUS = 5'h0b;
  localparam logic [4:0] ADDR_DIAL = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h0d;
  localparam logic [4:0] ADDR_TX_DATA = 5'h10;

  localparam int unsigned CTRL_OFFHOOK_BIT = 0;
  localparam int unsigned CTRL_TALK_BIT = 1;
  localparam int unsigned CTRL_TX_PAR_BIT = 2;
  localparam int unsigned CTRL_PULSE_BIT = 3;
  localparam int unsigned CTRL_EXT_CLK_BIT = 4;

  localparam int unsigned STAT_RING_BIT = 0;
  localparam int unsigned STAT_RX_FULL_BIT = 1;
  localparam int unsigned STAT_TX_EMPTY_BIT = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h04;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] RX_DATA_RESET = 8'h00;
  localparam logic [7:0] TX_DATA_RESET = 8'hff;
  localparam logic [7:0] MEM_RESET = 8'h00;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hff;

  typedef enum logic [1:0] {
    MHS_DIAL_IDLE = 2'b00,
    MHS_DIAL_BREAK = 2'b01,
    MHS_DIAL_MAKE = 2'b11
  } mhs_dial_state_type;

endpackage

// [hdl/mhs_regmem.sv]
// interface memory: 32 eight-bit registers, one write port, registered read
// assumes write strobe and addresses come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none

module mhs_regmem #(
  parameter int unsigned AW = mhs_pkg::ADDR_W,
  parameter int unsigned DW = mhs_pkg::DATA_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [2**AW];

  // every word takes its default while reset is held
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= mhs_pkg::MEM_RESET;
      end
    end else if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= mhs_pkg::MEM_RESET;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule

`default_nettype wire

// [hdl/mhs_top.sv]
// modem host bus port, serial data port, relay drivers and ring measurement
// assumes host pins are asynchronous; the modulator/demodulator sit on core_clk_i
`timescale 1ns/1ns
`default_nettype none

module mhs_top #(
  parameter int unsigned HALF_BIT_CYCLES = mhs_pkg::HALF_BIT_CYCLES,
  parameter int unsigned RING_MIN_CYCLES = mhs_pkg::RING_MIN_CYCLES,
  parameter int unsigned RING_MAX_CYCLES = mhs_pkg::RING_MAX_CYCLES,
  parameter int unsigned DIAL_BREAK_CYCLES = mhs_pkg::DIAL_BREAK_CYCLES,
  parameter int unsigned DIAL_MAKE_CYCLES = mhs_pkg::DIAL_MAKE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ext_tx_clock_in_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [4:0] reg_select_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic irq_o,
  output logic irq_oe_n_o,
  output logic offhook_relay_drive_o,
  output logic offhook_relay_drive_oe_n_o,
  output logic talk_relay_drive_o,
  output logic talk_relay_drive_oe_n_o,
  input wire logic ring_i,
  input wire logic rx_demod_bit_i,
  input wire logic rx_demod_strobe_i,
  output logic rx_serial_o,
  output logic rx_bit_clock_o,
  input wire logic tx_serial_i,
  output logic tx_bit_clock_o,
  output logic tx_mod_bit_o,
  output logic tx_mod_strobe_o
);

  localparam int unsigned SYNC_W = 18;
  localparam int unsigned CW = mhs_pkg::BIT_CNT_W;
  localparam int unsigned LW = mhs_pkg::LONG_CNT_W;
  localparam logic [CW-1:0] HALF_M1 = CW'(HALF_BIT_CYCLES - 1);
  localparam logic [CW-1:0] FULL_M1 = CW'(2 * HALF_BIT_CYCLES - 1);

  // wraps a bit-period counter; shared by both bit clock dividers
  function automatic logic [CW-1:0] bit_count_next(input logic [CW-1:0] cnt);
    bit_count_next = (cnt == FULL_M1) ? '0 : cnt + CW'(1);
  endfunction

  // pin synchronisers; only the second stage is read
  logic [SYNC_W-1:0] pin_m_q;
  logic [SYNC_W-1:0] pin_s_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_m_q <= '1;
      pin_s_q <= '1;
    end else begin
      pin_m_q <= {cs_n_i, rd_n_i, wr_n_i, ring_i, tx_serial_i, reg_select_i, data_i};
      pin_s_q <= pin_m_q;
    end
  end

  logic cs_n_s, rd_n_s, wr_n_s, ring_s, tx_serial_s;
  logic [4:0] addr_s;
  logic [7:0] data_s;
  assign {cs_n_s, rd_n_s, wr_n_s, ring_s, tx_serial_s, addr_s, data_s} = pin_s_q;

  // host strobe tracking: the write lands on the trailing edge of the access
  logic rd_act, wr_act, rd_act_q, wr_act_q, rd_done, wr_fire;
  logic [4:0] addr_q;
  logic [7:0] wdata_q;
  assign rd_act = !cs_n_s && !rd_n_s;
  assign wr_act = !cs_n_s && !wr_n_s;
  assign rd_done = rd_act_q && !rd_act;
  assign wr_fire = wr_act_q && !wr_act;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (rd_act || wr_act) begin
        addr_q <= addr_s;
      end
      if (wr_act) begin
        wdata_q <= data_s;
      end
    end
  end

  logic [7:0] mem_rdata;
  mhs_regmem #(.AW(mhs_pkg::ADDR_W), .DW(mhs_pkg::DATA_W)) u_mem (
    .clk_i(core_clk_i),
    .reset_i(reset_i),
    .we_i(wr_fire),
    .waddr_i(addr_q),
    .wdata_i(wdata_q),
    .raddr_i(addr_s),
    .rdata_o(mem_rdata)
  );

  // registers with hardware behaviour live here; the memory shadows the rest
  logic [7:0] ctrl_q, irq_en_q, status_q, rx_data_q, tx_data_q, status_d;
  logic ring_valid, rx_byte_done, tx_reload;
  logic wr_status, wr_ctrl, wr_irq_en, wr_tx, rd_rx;
  assign wr_ctrl = wr_fire && (addr_q == mhs_pkg::ADDR_CTRL);
  assign wr_status = wr_fire && (addr_q == mhs_pkg::ADDR_STATUS);
  assign wr_irq_en = wr_fire && (addr_q == mhs_pkg::ADDR_IRQ_EN);
  assign wr_tx = wr_fire && (addr_q == mhs_pkg::ADDR_TX_DATA);
  assign rd_rx = rd_done && (addr_q == mhs_pkg::ADDR_RX_DATA);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= mhs_pkg::CTRL_RESET;
      irq_en_q <= mhs_pkg::IRQ_EN_RESET;
      tx_data_q <= mhs_pkg::TX_DATA_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q;
      end
      if (wr_irq_en) begin
        irq_en_q <= wdata_q;
      end
      if (wr_tx) begin
        tx_data_q <= wdata_q;
      end
    end
  end

  // status flags: write one to clear, but a same-cycle hardware set wins
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~wdata_q;
    end
    if (rd_rx) begin
      status_d[mhs_pkg::STAT_RX_FULL_BIT] = 1'b0;
    end
    if (wr_tx) begin
      status_d[mhs_pkg::STAT_TX_EMPTY_BIT] = 1'b0;
    end
    if (ring_valid) begin
      status_d[mhs_pkg::STAT_RING_BIT] = 1'b1;
    end
    if (rx_byte_done) begin
      status_d[mhs_pkg::STAT_RX_FULL_BIT] = 1'b1;
    end
    if (tx_reload) begin
      status_d[mhs_pkg::STAT_TX_EMPTY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_q <= mhs_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // read data follows the live address while the read strobe is held
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_o <= '0;
      data_oe_n_o <= 1'b1;
    end else begin
      data_oe_n_o <= !(rd_act && rd_act_q);
      case (addr_s)
        mhs_pkg::ADDR_RX_DATA: data_o <= rx_data_q;
        mhs_pkg::ADDR_CTRL: data_o <= ctrl_q;
        mhs_pkg::ADDR_STATUS: data_o <= status_q;
        mhs_pkg::ADDR_IRQ_EN: data_o <= irq_en_q;
        mhs_pkg::ADDR_TX_DATA: data_o <= tx_data_q;
        default: data_o <= mem_rdata;
      endcase
    end
  end

  // receive side: the demodulator strobe marks the start of each bit
  logic [CW-1:0] rx_cnt_q;
  logic [7:0] rx_shift_q;
  logic [2:0] rx_bits_q;
  assign rx_byte_done = rx_demod_strobe_i && (rx_bits_q == 3'h7);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_cnt_q <= '0;
      rx_bit_clock_o <= 1'b0;
      rx_serial_o <= 1'b1;
      rx_shift_q <= '0;
      rx_bits_q <= '0;
      rx_data_q <= mhs_pkg::RX_DATA_RESET;
    end else begin
      if (rx_demod_strobe_i) begin
        rx_cnt_q <= '0;
        rx_bit_clock_o <= 1'b0;
        rx_serial_o <= rx_demod_bit_i;
        rx_shift_q <= {rx_demod_bit_i, rx_shift_q[7:1]};
        rx_bits_q <= rx_bits_q + 3'h1;
        if (rx_byte_done) begin
          rx_data_q <= {rx_demod_bit_i, rx_shift_q[7:1]};
        end
      end else begin
        // rises half a bit after the bit start, i.e. at the bit centre
        rx_cnt_q <= bit_count_next(rx_cnt_q);
        if (rx_cnt_q == HALF_M1) begin
          rx_bit_clock_o <= 1'b1;
        end else if (rx_cnt_q == FULL_M1) begin
          rx_bit_clock_o <= 1'b0;
        end
      end
    end
  end

  // external transmit clock domain: capture the bit and toggle an event flag
  logic ext_bit_q, ext_tog_q;
  always_ff @(posedge ext_tx_clock_in_i or posedge reset_i) begin
    if (reset_i) begin
      ext_bit_q <= 1'b1;
      ext_tog_q <= 1'b0;
    end else begin
      ext_bit_q <= tx_serial_i;
      ext_tog_q <= !ext_tog_q;
    end
  end

  // ext_bit_q stays put for a whole external period, far longer than the
  // toggle takes to cross, so it is stable when the core samples it
  logic ext_tog_m_q, ext_tog_s_q, ext_tog_d_q, ext_evt;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_tog_m_q <= 1'b0;
      ext_tog_s_q <= 1'b0;
      ext_tog_d_q <= 1'b0;
    end else begin
      ext_tog_m_q <= ext_tog_q;
      ext_tog_s_q <= ext_tog_m_q;
      ext_tog_d_q <= ext_tog_s_q;
    end
  end
  assign ext_evt = ext_tog_s_q ^ ext_tog_d_q;

  // transmit side: internal bit clock, falling edge starts a bit
  logic [CW-1:0] tx_cnt_q;
  logic tx_sample_q, tx_tick, tx_par, tx_ext;
  logic [7:0] tx_shift_q;
  logic [2:0] tx_bits_q;
  assign tx_par = ctrl_q[mhs_pkg::CTRL_TX_PAR_BIT];
  assign tx_ext = ctrl_q[mhs_pkg::CTRL_EXT_CLK_BIT];
  assign tx_tick = tx_ext ? ext_evt : (tx_cnt_q == FULL_M1);
  assign tx_reload = tx_tick && tx_par && (tx_bits_q == 3'h7);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_cnt_q <= '0;
      tx_bit_clock_o <= 1'b0;
      tx_sample_q <= 1'b1;
    end else begin
      tx_cnt_q <= bit_count_next(tx_cnt_q);
      if (tx_cnt_q == HALF_M1) begin
        tx_bit_clock_o <= 1'b1;
        tx_sample_q <= tx_serial_s;
      end else if (tx_cnt_q == FULL_M1) begin
        tx_bit_clock_o <= 1'b0;
      end
    end
  end

  // an empty transmit register sends idle marks rather than stale data
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_mod_bit_o <= 1'b1;
      tx_mod_strobe_o <= 1'b0;
      tx_shift_q <= mhs_pkg::TX_IDLE_BYTE;
      tx_bits_q <= '0;
    end else begin
      tx_mod_strobe_o <= tx_tick;
      if (tx_tick) begin
        if (!tx_par) begin
          tx_mod_bit_o <= tx_ext ? ext_bit_q : tx_sample_q;
        end else begin
          tx_mod_bit_o <= tx_shift_q[0];
          tx_bits_q <= tx_bits_q + 3'h1;
          if (tx_reload) begin
            tx_shift_q <= status_q[mhs_pkg::STAT_TX_EMPTY_BIT] ? mhs_pkg::TX_IDLE_BYTE
                                                                : tx_data_q;
          end else begin
            tx_shift_q <= {1'b1, tx_shift_q[7:1]};
          end
        end
      end
    end
  end

  // ring period measured between successive falling edges
  logic ring_d_q, ring_meas_q, ring_fall;
  logic [LW-1:0] ring_cnt_q;
  assign ring_fall = ring_d_q && !ring_s;
  assign ring_valid = ring_fall && ring_meas_q && (ring_cnt_q >= LW'(RING_MIN_CYCLES));

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ring_d_q <= 1'b1;
      ring_meas_q <= 1'b0;
      ring_cnt_q <= '0;
    end else begin
      ring_d_q <= ring_s;
      if (ring_fall) begin
        ring_meas_q <= 1'b1;
        ring_cnt_q <= '0;
      end else if (ring_meas_q) begin
        if (ring_cnt_q == LW'(RING_MAX_CYCLES)) begin
          ring_meas_q <= 1'b0;
        end else begin
          ring_cnt_q <= ring_cnt_q + LW'(1);
        end
      end
    end
  end

  // dial pulser: a write to the dial register loads a pulse count
  mhs_pkg::mhs_dial_state_type dial_state_q;
  logic [3:0] dial_left_q;
  logic [LW-1:0] dial_cnt_q;
  logic wr_dial, pulse_mode;
  assign wr_dial = wr_fire && (addr_q == mhs_pkg::ADDR_DIAL);
  assign pulse_mode = ctrl_q[mhs_pkg::CTRL_PULSE_BIT];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dial_state_q <= mhs_pkg::MHS_DIAL_IDLE;
      dial_left_q <= '0;
      dial_cnt_q <= '0;
    end else begin
      case (dial_state_q)
        mhs_pkg::MHS_DIAL_IDLE: begin
          if (wr_dial && pulse_mode && (wdata_q[3:0] != 4'h0)) begin
            dial_left_q <= wdata_q[3:0];
            dial_cnt_q <= '0;
            dial_state_q <= mhs_pkg::MHS_DIAL_BREAK;
          end
        end
        mhs_pkg::MHS_DIAL_BREAK: begin
          if (dial_cnt_q == LW'(DIAL_BREAK_CYCLES - 1)) begin
            dial_cnt_q <= '0;
            dial_left_q <= dial_left_q - 4'h1;
            dial_state_q <= mhs_pkg::MHS_DIAL_MAKE;
          end else begin
            dial_cnt_q <= dial_cnt_q + LW'(1);
          end
        end
        mhs_pkg::MHS_DIAL_MAKE: begin
          if (dial_cnt_q == LW'(DIAL_MAKE_CYCLES - 1)) begin
            dial_cnt_q <= '0;
            dial_state_q <= (dial_left_q == 4'h0) ? mhs_pkg::MHS_DIAL_IDLE
                                                  : mhs_pkg::MHS_DIAL_BREAK;
          end else begin
            dial_cnt_q <= dial_cnt_q + LW'(1);
          end
        end
        default: dial_state_q <= mhs_pkg::MHS_DIAL_IDLE;
      endcase
    end
  end

  // open-drain drivers: the level flops hold low, the enables switch
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      irq_oe_n_o <= 1'b1;
      offhook_relay_drive_o <= 1'b0;
      offhook_relay_drive_oe_n_o <= 1'b1;
      talk_relay_drive_o <= 1'b0;
      talk_relay_drive_oe_n_o <= 1'b1;
    end else begin
      irq_o <= 1'b0;
      offhook_relay_drive_o <= 1'b0;
      talk_relay_drive_o <= 1'b0;
      irq_oe_n_o <= !(|(status_q & irq_en_q));
      if (pulse_mode) begin
        offhook_relay_drive_oe_n_o <= (dial_state_q == mhs_pkg::MHS_DIAL_BREAK);
      end else begin
        offhook_relay_drive_oe_n_o <= !ctrl_q[mhs_pkg::CTRL_OFFHOOK_BIT];
      end
      talk_relay_drive_oe_n_o <= !ctrl_q[mhs_pkg::CTRL_TALK_BIT];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_rx_clk_rise;
    $rose(rx_bit_clock_o) |-> $past(rx_cnt_q) == HALF_M1 && !$past(rx_demod_strobe_i);
  endproperty
  a_rx_clk_rise: assert property (p_rx_clk_rise) else $error("rx clock rose off centre");
  property p_tx_clk_rise;
    $rose(tx_bit_clock_o) |-> $past(tx_cnt_q) == HALF_M1;
  endproperty
  a_tx_clk_rise: assert property (p_tx_clk_rise) else $error("tx clock rose at wrong count");
  property p_ext_bit;
    (ext_evt && tx_ext && !tx_par) |=> tx_mod_bit_o == $past(ext_bit_q) && tx_mod_strobe_o;
  endproperty
  a_ext_bit: assert property (p_ext_bit) else $error("external clocked bit not sent");
  property p_rx_serial;
    rx_demod_strobe_i |=> rx_serial_o == $past(rx_demod_bit_i) && !rx_bit_clock_o;
  endproperty
  a_rx_serial: assert property (p_rx_serial) else $error("received bit not presented");
  property p_tx_par;
    (tx_tick && tx_par) |=> tx_mod_bit_o == $past(tx_shift_q[0]);
  endproperty
  a_tx_par: assert property (p_tx_par) else $error("parallel tx bit wrong");
  property p_cs_gate;
    !data_oe_n_o |-> !$past(cs_n_s) && !$past(cs_n_s, 2);
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("bus driven without chip select");
  property p_ctrl_write;
    wr_ctrl |=> ctrl_q == $past(wdata_q);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
  property p_irq;
    !irq_oe_n_o |-> |($past(status_q) & $past(irq_en_q));
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enabled status");
  property p_offhook;
    (!pulse_mode && $stable(ctrl_q)) |=>
      offhook_relay_drive_oe_n_o == !$past(ctrl_q[mhs_pkg::CTRL_OFFHOOK_BIT]);
  endproperty
  a_offhook: assert property (p_offhook) else $error("off-hook drive mismatch");
  property p_talk;
    $stable(ctrl_q) |=> talk_relay_drive_oe_n_o == !$past(ctrl_q[mhs_pkg::CTRL_TALK_BIT]);
  endproperty
  a_talk: assert property (p_talk) else $error("talk relay drive mismatch");
  property p_ring;
    ring_valid |=> status_q[mhs_pkg::STAT_RING_BIT];
  endproperty
  a_ring: assert property (p_ring) else $error("valid ring not flagged");
  property p_dial_break;
    (pulse_mode && dial_state_q == mhs_pkg::MHS_DIAL_BREAK) |=> offhook_relay_drive_oe_n_o;
  endproperty
  a_dial_break: assert property (p_dial_break) else $error("relay held during break");

  c_ring: cover property (ring_valid);
  c_rx_byte: cover property (rx_byte_done ##[1:40] rd_rx);
  c_tx_reload: cover property (wr_tx ##[1:1000] tx_reload);
  c_dial: cover property (dial_state_q == mhs_pkg::MHS_DIAL_MAKE);

endmodule

`default_nettype wire

// [bench/mhs_partner.sv]
// far-side model: demodulator bit source and terminal transmit clock
// assumes it is driven from the falling edges of the core clock
`timescale 1ns/1ns
`default_nettype none
module mhs_partner (
  input wire logic clk_i,
  input wire logic ext_run_i,
  output var logic bit_o = 1'b0,
  output var logic strobe_o = 1'b0,
  output var logic ext_clk_o = 1'b0
);
  // one bit every 16 cycles; the line shows the inverse between strobes
  task automatic send_bit(input logic b);
    @(negedge clk_i);
    {bit_o, strobe_o} = {b, 1'b1};
    @(negedge clk_i);
    {bit_o, strobe_o} = {~b, 1'b0};
    repeat (14) @(negedge clk_i);
  endtask
  // 125 ns terminal clock, stands low outside frames
  always begin
    #62 ext_clk_o = ext_run_i;
    #63 ext_clk_o = 1'b0;
  end
endmodule
`default_nettype wire

// [bench/mhs_top_tb.sv]
// bench for the modem host and serial port block
// assumes mhs_pkg, mhs_top and mhs_partner are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module mhs_top_tb;
  logic core_clk = 1'b0, reset = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic tx_ser = 1'b1, ring = 1'b1, ext_run = 1'b0;
  logic [4:0] rs = 5'h00;
  logic [7:0] hd = 8'h00, dout;
  logic doe_n, irq_oe_n, oh_oe_n, tk_oe_n, rxs, rxc, txb, txs, txc, pbit, pstb, pext;
  logic [2:0] od;
  int fail_count = 0, samples_checked = 0;
  wire [7:0] bus = doe_n ? hd : dout;
  mhs_top #(.HALF_BIT_CYCLES(8), .RING_MIN_CYCLES(50), .RING_MAX_CYCLES(200),
    .DIAL_BREAK_CYCLES(20), .DIAL_MAKE_CYCLES(10)) mhs_top_i (.core_clk_i(core_clk),
    .reset_i(reset), .ext_tx_clock_in_i(pext), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .reg_select_i(rs), .data_i(bus), .data_o(dout), .data_oe_n_o(doe_n), .irq_o(od[0]),
    .irq_oe_n_o(irq_oe_n), .offhook_relay_drive_o(od[1]),
    .offhook_relay_drive_oe_n_o(oh_oe_n),
    .talk_relay_drive_o(od[2]), .talk_relay_drive_oe_n_o(tk_oe_n), .ring_i(ring),
    .rx_demod_bit_i(pbit), .rx_demod_strobe_i(pstb), .rx_serial_o(rxs), .rx_bit_clock_o(rxc),
    .tx_serial_i(tx_ser), .tx_bit_clock_o(txc), .tx_mod_bit_o(txb), .tx_mod_strobe_o(txs));
  mhs_partner mhs_partner_i (.clk_i(core_clk), .ext_run_i(ext_run), .bit_o(pbit),
    .strobe_o(pstb), .ext_clk_o(pext));
  initial
    forever #5 core_clk = ~core_clk;
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    results();
  end
  task automatic results();
    $display("checked %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // strobe held 6 cycles: the pins pass a two-stage synchroniser first
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] v, input logic sel_n = 1'b0);
    @(negedge core_clk);
    {cs_n, wr_n, rd_n, rs, hd} = {sel_n, !w, w, a, d};
    repeat (6) @(negedge core_clk);
    v = dout;
    if (!w) `CHK("read drive", 1'b0, doe_n)
    {cs_n, wr_n, rd_n} = 3'b111;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic sel_n = 1'b0);
    logic [7:0] v;
    acc(1'b1, a, d, v, sel_n);
  endtask
  task automatic wait_txs(output int n);
    n = 0;
    do
      @(negedge core_clk) n++;
    while (txs !== 1'b1 && n < 200);
    fail_count += int'(n >= 200);
    if (n >= 200) results();
  endtask
  task automatic t_regs();
    logic [7:0] v;
    acc(1'b0, 5'h0b, 8'h00, v);
    `CHK("status", 8'h04, v)
    wr(5'h1f, 8'ha5);
    wr(5'h1f, 8'h5a, 1'b1);
    acc(1'b0, 5'h1f, 8'h00, v);
    `CHK("reg 1f", 8'ha5, v)
    $display("register test done");
  endtask
  task automatic t_relay();
    logic [7:0] c[3] = '{8'h01, 8'h02, 8'h00};
    foreach (c[i]) begin
      wr(5'h09, c[i]);
      `CHK("hook relay", ~c[i][0], oh_oe_n)
      `CHK("talk relay", ~c[i][1], tk_oe_n)
    end
    $display("relay test done");
  endtask
  task automatic t_rx();
    logic [7:0] v, b;
    b = 8'h96;
    for (int i = 0; i < 8; i++) begin
      fork
        mhs_partner_i.send_bit(b[i]);
        begin
          repeat (12) @(negedge core_clk);
          `CHK("rx clock", 1'b1, rxc)
        end
      join
      `CHK("rx serial", b[i], rxs)
    end
    acc(1'b0, 5'h00, 8'h00, v);
    `CHK("rx data", b, v)
    $display("receive test done");
  endtask
  task automatic t_tx();
    int n, j;
    logic [31:0] h;
    wr(5'h10, 8'h3c);
    wr(5'h09, 8'h04);
    for (int k = 0; k < 32; k++) begin
      wait_txs(n);
      h[k] = txb;
    end
    `CHK("bit period", 16, n)
    // the clock falls on the tick edge and rises half a period later
    `CHK("tx clock low", 1'b0, txc)
    repeat (8) @(negedge core_clk);
    `CHK("tx clock high", 1'b1, txc)
    j = 0;
    // idle bytes are all ones, so the first zero opens the byte
    while (j < 24 && h[j] === 1'b1) j++;
    `CHK("parallel byte", 8'h3c, h[j+:8])
    tx_ser = 1'b0;
    wr(5'h09, 8'h00);
    repeat (3) wait_txs(n);
    `CHK("serial bit", 1'b0, txb)
    ext_run = 1'b1;
    wr(5'h09, 8'h10);
    repeat (3) wait_txs(n);
    `CHK("ext period", 1'b1, n == 12 || n == 13)
    // zero differs from the capture flop's reset level
    `CHK("ext bit", 1'b0, txb)
    $display("transmit test done");
  endtask
  task automatic t_ring();
    logic [7:0] v;
    wr(5'h0d, 8'h01);
    `CHK("irq idle", 1'b1, irq_oe_n)
    ring = 1'b0;
    repeat (50) @(negedge core_clk);
    ring = 1'b1;
    repeat (50) @(negedge core_clk);
    ring = 1'b0;
    repeat (10) @(negedge core_clk);
    `CHK("irq", 1'b0, irq_oe_n)
    `CHK("open-drain levels", 3'h0, od)
    acc(1'b0, 5'h0b, 8'h00, v);
    `CHK("ring flag", 1'b1, v[0])
    wr(5'h0d, 8'h00);
    `CHK("irq masked", 1'b1, irq_oe_n)
    $display("ring test done");
  endtask
  // pulse mode with the off-hook bit clear: only the pulser moves the relay
  task automatic t_dial();
    logic e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(5'h09, 8'h08);
    `CHK("dial idle", 1'b0, oh_oe_n)
    wr(5'h0c, 8'h02);
    foreach (e[i]) begin
      `CHK("dial pulse", e[i], oh_oe_n)
      repeat (20) @(negedge core_clk);
    end
    wr(5'h09, 8'h00);
    `CHK("dial done", 1'b1, oh_oe_n)
    $display("dial test done");
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    t_regs();
    t_relay();
    t_rx();
    t_tx();
    t_dial();
    t_ring();
    results();
  end
endmodule
`default_nettype wire
